// >>> include/isrs_pkg.sv
// Shared constants and types of the dual-protocol register slave port
package isrs_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Two-wire addressing
	// ----------------------------------------------------------------
	localparam logic [5:0] I2C_ADDR_HI = 6'h0e;

	// ----------------------------------------------------------------
	// Bit, cycle and entry counts
	// ----------------------------------------------------------------
	localparam logic [3:0] I2C_BYTE_DONE = 4'h8;
	localparam logic [3:0] I2C_ACK_SLOT  = 4'h9;
	localparam logic [3:0] SPI_HDR_LAST  = 4'h7;
	localparam logic [3:0] SPI_DATA_BIT0 = 4'h8;
	localparam logic [3:0] SPI_BYTE_LAST = 4'hf;
	localparam logic [1:0] STRAP_TAKE    = 2'h2;
	localparam logic [1:0] BUF_DEPTH     = 2'h2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] PINS_IDLE = 4'he;
	localparam logic [7:0] TX_IDLE   = 8'hff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic scl;
		logic sda;
		logic sdo;
	} isrs_pins_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} isrs_wr_s;

	typedef enum logic [4:0] {
		I_IDLE = 5'b00001,
		I_DEV  = 5'b00010,
		I_SUB  = 5'b00100,
		I_WDAT = 5'b01000,
		I_RDAT = 5'b10000
	} isrs_i2c_e;

endpackage

// >>> rtl/isrs_register_slave.sv
// Dual two-wire / SPI register slave port with a two-entry write buffer
`timescale 1ns/1ns

module isrs_register_slave
	import isrs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic               sys_clk,
	input  wire logic               reset,
	input  wire logic               ce,
	// Serial pads
	input  wire logic               cs_n,
	input  wire logic               scl_in,
	output logic                    scl_out,
	output logic                    scl_oe,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe,
	input  wire logic               sdo_in,
	output logic                    sdo_out,
	output logic                    sdo_oe,
	// Configuration and status
	input  wire logic               three_wire_select,
	output logic                    bus_busy,
	// Register file side
	output logic                    wr_valid,
	output isrs_pkg::isrs_wr_s      wr_req,
	input  wire logic               wr_ready,
	output logic [ADDR_W-1:0]       rd_addr,
	input  wire logic [DATA_W-1:0]  rd_data
);
	import isrs_pkg::*;

	// ----------------------------------------------------------------
	// Pad synchronisers and edge detection
	// ----------------------------------------------------------------
	isrs_pins_s pin_m, pin_s, pin_p;
	logic       spi_mode, scl_rise, scl_fall, i2c_start, i2c_stop;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_m <= PINS_IDLE;
			pin_s <= PINS_IDLE;
			pin_p <= PINS_IDLE;
		end else if (ce) begin
			pin_m <= '{cs_n: cs_n, scl: scl_in, sda: sda_in, sdo: sdo_in};
			pin_s <= pin_m;
			pin_p <= pin_s;
		end
	end

	assign spi_mode  = ~pin_s.cs_n;
	assign scl_rise  = pin_s.scl & ~pin_p.scl;
	assign scl_fall  = ~pin_s.scl & pin_p.scl;
	assign i2c_start = ~spi_mode & pin_s.scl & pin_p.scl & pin_p.sda & ~pin_s.sda;
	assign i2c_stop  = ~spi_mode & pin_s.scl & pin_p.scl & ~pin_p.sda & pin_s.sda;

	// ----------------------------------------------------------------
	// Address strap, caught once the synchroniser has filled
	// ----------------------------------------------------------------
	logic [1:0] strap_cnt;
	logic       addr_lsb;
	logic [6:0] own_addr;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			strap_cnt <= 2'h0;
			addr_lsb  <= 1'b0;
		end else if (ce && strap_cnt != 2'h3) begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == STRAP_TAKE)
				addr_lsb <= pin_s.sdo;
		end
	end

	assign own_addr = {I2C_ADDR_HI, addr_lsb};

	// ----------------------------------------------------------------
	// Two-wire slave
	// ----------------------------------------------------------------
	isrs_i2c_e   i_state;
	logic [3:0]  i_cnt;
	logic [7:0]  i_sh, i_tx;
	logic [6:0]  i_ptr;
	logic        i_rw, i_auto, i_low, i_push;
	isrs_wr_s    i_pw;
	logic        pend;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			i_state <= I_IDLE;
			i_cnt   <= 4'h0;
			i_sh    <= 8'h00;
			i_tx    <= TX_IDLE;
			i_ptr   <= 7'h00;
			i_rw    <= 1'b0;
			i_auto  <= 1'b0;
			i_low   <= 1'b0;
			i_push  <= 1'b0;
			i_pw    <= '0;
		end else if (ce) begin
			i_push <= 1'b0;
			if (spi_mode) begin
				i_state <= I_IDLE;
				i_low   <= 1'b0;
			end else if (i2c_start) begin
				i_state <= I_DEV;
				i_cnt   <= 4'h0;
				i_low   <= 1'b0;
			end else if (i2c_stop) begin
				i_state <= I_IDLE;
				i_low   <= 1'b0;
			end else if (i_state == I_RDAT) begin
				if (scl_rise) begin
					if (i_cnt < I2C_BYTE_DONE)
						i_cnt <= i_cnt + 4'h1;
					else if (i_cnt == I2C_BYTE_DONE) begin
						if (!pin_s.sda)
							i_cnt <= I2C_ACK_SLOT;
						else
							i_state <= I_IDLE;
					end
				end else if (scl_fall) begin
					if (i_cnt == I2C_BYTE_DONE)
						i_low <= 1'b0;
					else if (i_cnt == I2C_ACK_SLOT) begin
						i_cnt <= 4'h0;
						i_low <= ~rd_data[7];
						i_tx  <= {rd_data[6:0], 1'b1};
						if (i_auto)
							i_ptr <= i_ptr + 7'h01;
					end else if (i_cnt != 4'h0) begin
						i_low <= ~i_tx[7];
						i_tx  <= {i_tx[6:0], 1'b1};
					end
				end
			end else if (i_state != I_IDLE) begin
				if (scl_rise && i_cnt < I2C_BYTE_DONE) begin
					i_sh  <= {i_sh[6:0], pin_s.sda};
					i_cnt <= i_cnt + 4'h1;
				end else if (scl_fall && i_cnt == I2C_BYTE_DONE) begin
					i_cnt <= I2C_ACK_SLOT;
					unique case (i_state)
						I_DEV: begin
							if (i_sh[7:1] == own_addr) begin
								i_low <= 1'b1;
								i_rw  <= i_sh[0];
							end else
								i_state <= I_IDLE;
						end
						I_SUB: begin
							i_low  <= 1'b1;
							i_ptr  <= i_sh[6:0];
							i_auto <= i_sh[7];
						end
						default: begin
							i_low  <= 1'b1;
							i_push <= 1'b1;
							i_pw   <= '{addr: i_ptr, data: i_sh};
						end
					endcase
				end else if (scl_fall && i_cnt == I2C_ACK_SLOT) begin
					i_cnt <= 4'h0;
					i_low <= 1'b0;
					unique case (i_state)
						I_DEV: begin
							if (i_rw) begin
								i_state <= I_RDAT;
								i_low   <= ~rd_data[7];
								i_tx    <= {rd_data[6:0], 1'b1};
								if (i_auto)
									i_ptr <= i_ptr + 7'h01;
							end else
								i_state <= I_SUB;
						end
						I_SUB:
							i_state <= I_WDAT;
						default: begin
							if (i_auto)
								i_ptr <= i_ptr + 7'h01;
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// SPI slave
	// ----------------------------------------------------------------
	logic [3:0] s_cnt;
	logic [7:0] s_sh, s_tx;
	logic [6:0] s_ptr;
	logic       s_rw, s_inc, s_drv, s_out, s_push;
	isrs_wr_s   s_pw;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_cnt  <= 4'h0;
			s_sh   <= 8'h00;
			s_tx   <= 8'h00;
			s_ptr  <= 7'h00;
			s_rw   <= 1'b0;
			s_inc  <= 1'b0;
			s_drv  <= 1'b0;
			s_out  <= 1'b0;
			s_push <= 1'b0;
			s_pw   <= '0;
		end else if (ce) begin
			s_push <= 1'b0;
			if (!spi_mode) begin
				s_cnt <= 4'h0;
				s_drv <= 1'b0;
			end else if (scl_rise) begin
				s_sh <= {s_sh[6:0], pin_s.sda};
				if (s_cnt == SPI_HDR_LAST) begin
					s_rw  <= s_sh[6];
					s_inc <= s_sh[5];
					s_ptr <= {1'b0, s_sh[4:0], pin_s.sda};
				end
				if (s_cnt == SPI_BYTE_LAST) begin
					s_cnt <= SPI_DATA_BIT0;
					if (!s_rw) begin
						s_push <= 1'b1;
						s_pw   <= '{addr: s_ptr, data: {s_sh[6:0], pin_s.sda}};
						if (s_inc)
							s_ptr <= s_ptr + 7'h01;
					end
				end else
					s_cnt <= s_cnt + 4'h1;
			end else if (scl_fall && s_rw && s_cnt == SPI_DATA_BIT0) begin
				s_drv <= 1'b1;
				s_out <= rd_data[7];
				s_tx  <= {rd_data[6:0], 1'b0};
				if (s_inc)
					s_ptr <= s_ptr + 7'h01;
			end else if (scl_fall && s_drv) begin
				s_out <= s_tx[7];
				s_tx  <= {s_tx[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Pending write and two-entry buffer
	// ----------------------------------------------------------------
	isrs_wr_s   pw, buf_mem [2];
	logic [1:0] buf_cnt;
	logic       buf_wp, buf_rp, buf_push, buf_pop;

	assign buf_push = pend && buf_cnt != BUF_DEPTH;
	assign buf_pop  = wr_valid && wr_ready;
	assign wr_valid = buf_cnt != 2'h0;
	assign wr_req   = buf_mem[buf_rp];

	// A new byte wins over the clear of the old one
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pend <= 1'b0;
			pw   <= '0;
		end else if (ce) begin
			if (i_push || s_push) begin
				pend <= 1'b1;
				pw   <= i_push ? i_pw : s_pw;
			end else if (buf_push)
				pend <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			buf_cnt    <= 2'h0;
			buf_wp     <= 1'b0;
			buf_rp     <= 1'b0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else if (ce) begin
			if (buf_push) begin
				buf_mem[buf_wp] <= pw;
				buf_wp          <= ~buf_wp;
			end
			if (buf_pop)
				buf_rp <= ~buf_rp;
			if (buf_push && !buf_pop)
				buf_cnt <= buf_cnt + 2'h1;
			else if (buf_pop && !buf_push)
				buf_cnt <= buf_cnt - 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Registered pad drive
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scl_oe   <= 1'b0;
			sda_oe   <= 1'b0;
			sda_out  <= 1'b0;
			sdo_oe   <= 1'b0;
			sdo_out  <= 1'b0;
			rd_addr  <= 7'h00;
			bus_busy <= 1'b0;
		end else if (ce) begin
			// Stretch only while the clock is already low
			scl_oe   <= pend && !spi_mode && !pin_s.scl;
			sda_oe   <= spi_mode ? (s_drv && three_wire_select) : i_low;
			sda_out  <= spi_mode && s_out;
			sdo_oe   <= spi_mode && s_drv && !three_wire_select;
			sdo_out  <= s_out;
			rd_addr  <= spi_mode ? s_ptr : i_ptr;
			bus_busy <= spi_mode || i_state != I_IDLE;
		end
	end

	assign scl_out = 1'b0;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence i2c_byte_end;
		ce && !spi_mode && !i2c_start && !i2c_stop && scl_fall && i_cnt == I2C_BYTE_DONE;
	endsequence
	sequence spi_byte_end;
		ce && spi_mode && scl_rise && s_cnt == SPI_BYTE_LAST;
	endsequence

	a_i2c_addr_ack: assert property (i2c_byte_end and i_state == I_DEV
		and i_sh[7:1] == own_addr |=> i_low ##1 (!spi_mode -> sda_oe))
		else $error("own address not acknowledged");
	a_i2c_nomatch: assert property (i2c_byte_end and i_state == I_DEV
		and i_sh[7:1] != own_addr |=> i_state == I_IDLE && !i_low)
		else $error("foreign address not ignored");
	a_i2c_commit: assert property (i2c_byte_end and i_state == I_WDAT
		|=> i_push && i_pw.data == $past(i_sh) ##1 pend)
		else $error("two-wire byte not committed");
	a_spi_wrap: assert property (spi_byte_end |=> s_cnt == SPI_DATA_BIT0)
		else $error("SPI block count wrong");
	a_spi_write: assert property (spi_byte_end and !s_rw
		|=> s_push && s_pw.addr == $past(s_ptr))
		else $error("SPI write not committed");
	a_spi_fixaddr: assert property (spi_byte_end and !s_inc
		|=> $stable(s_ptr))
		else $error("SPI address moved without increment");
	a_spi_abort: assert property (ce && !spi_mode |=> s_cnt == 4'h0 && !s_drv
		&& !s_push) else $error("SPI not aborted on select rise");
	a_spi_rd_start: assert property (ce && spi_mode && scl_fall && s_rw
		&& s_cnt == SPI_DATA_BIT0 |=> s_drv ##1 (spi_mode -> (sda_oe || sdo_oe)))
		else $error("SPI read drive not started");
	a_wire3_pin: assert property (ce && spi_mode && s_drv && three_wire_select
		|=> sda_oe && !sdo_oe) else $error("three-wire data on wrong pin");
	a_wire4_pin: assert property (ce && spi_mode && s_drv && !three_wire_select
		|=> sdo_oe && !sda_oe) else $error("four-wire data on wrong pin");
	a_buf_full: assert property (ce && pend && buf_cnt == BUF_DEPTH && !i_push && !s_push
		|=> pend && pw == $past(pw)) else $error("pending write lost while buffer full");
	a_scl_stretch: assert property (ce && pend && !spi_mode && !pin_s.scl |=> scl_oe)
		else $error("clock not stretched for pending write");

endmodule // isrs_register_slave

// >>> verification/isrs_master_model.sv
// Serial bus master model for the shared two-wire / SPI pads
`timescale 1ns/1ns
module isrs_master_model (
	// Clock and mode
	input  wire logic sys_clk,
	input  wire logic three_wire_select,
	// Resolved pad levels
	output logic      cs_n,
	output logic      scl_line,
	output logic      sda_line,
	output logic      sdo_line,
	// Slave drivers
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic sda_out,
	input  wire logic sdo_oe,
	input  wire logic sdo_out
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	logic early = 1'b0;
	initial cs_n = 1'b1;

	// Pull-ups: a released line reads high
	assign scl_line = (scl_oe || !m_scl) ? 1'b0 : 1'b1;
	assign sda_line = sda_oe ? sda_out : m_sda;
	assign sdo_line = sdo_oe ? sdo_out : 1'b1;

	task automatic half();
		repeat (4) @(negedge sys_clk);
	endtask

	// Waits out a clock stretch, bounded
	task automatic rise();
		m_scl = 1'b1;
		for (int w = 0; w < 400 && !scl_line; w++) @(negedge sys_clk);
	endtask

	task automatic spi(input int n, input logic [63:0] mo, input bit rd,
			output logic [63:0] mi);
		mi = '0;
		early = 1'b0;
		cs_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			m_scl = 1'b0;
			m_sda = (rd && i > 7) ? 1'b1 : mo[63-i];
			half();
			m_scl = 1'b1;
			mi[63-i] = three_wire_select ? sda_line : sdo_line;
			if (i < 8 && (sdo_oe || sda_oe))
				early = 1'b1;
			half();
		end
		m_sda = 1'b1;
		cs_n = 1'b1;
		half();
	endtask

	task automatic i2c_start();
		half();
		m_sda = 1'b1;
		half();
		rise();
		half();
		m_sda = 1'b0;
		half();
		m_scl = 1'b0;
	endtask

	task automatic i2c_stop();
		half();
		m_sda = 1'b0;
		half();
		rise();
		half();
		m_sda = 1'b1;
		half();
	endtask

	// Bit 0 of tx/rx is the acknowledge slot
	task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			@(negedge sys_clk);
			m_sda = tx[i];
			half();
			rise();
			repeat (2) @(negedge sys_clk);
			rx[i] = sda_line;
			repeat (2) @(negedge sys_clk);
			m_scl = 1'b0;
		end
	endtask
endmodule // isrs_master_model

// >>> verification/isrs_register_slave_tb_top.sv
// Self-checking bench with register file and write model
`timescale 1ns/1ns
module isrs_register_slave_tb_top;
	import isrs_pkg::*;
	logic              sys_clk, reset, three_wire_select, wr_ready, wr_valid, ce;
	logic              cs_n, scl_line, sda_line, sdo_line, bus_busy, scl_out;
	logic              scl_oe, sda_oe, sda_out, sdo_oe, sdo_out;
	isrs_wr_s          wr_req;
	logic [ADDR_W-1:0] rd_addr;
	logic [7:0]        mem [128];
	logic [7:0]        exp_mem [128];
	logic [14:0]       exp_q [$];
	logic [63:0]       miso;
	logic [8:0]        rx;
	int                miscompares = 0;
	int                check_count = 0;

	isrs_register_slave u_isrs_register_slave (.sys_clk(sys_clk), .reset(reset), .ce(ce),
		.cs_n(cs_n), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .sdo_in(sdo_line), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .three_wire_select(three_wire_select), .bus_busy(bus_busy),
		.wr_valid(wr_valid), .wr_req(wr_req), .wr_ready(wr_ready), .rd_addr(rd_addr),
		.rd_data(mem[rd_addr]));
	isrs_master_model u_isrs_master_model (.sys_clk(sys_clk),
		.three_wire_select(three_wire_select), .cs_n(cs_n), .scl_line(scl_line),
		.sda_line(sda_line), .sdo_line(sdo_line), .scl_oe(scl_oe), .sda_oe(sda_oe),
		.sda_out(sda_out), .sdo_oe(sdo_oe), .sdo_out(sdo_out));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Random stalls by the register file
	always @(negedge sys_clk)
		wr_ready <= 1'($urandom);

	always @(posedge sys_clk)
		if (!reset && wr_valid && wr_ready) begin
			chk("write", exp_q.size() ? exp_q.pop_front() : 15'h7fff, wr_req);
			mem[wr_req.addr] = wr_req.data;
		end

	task automatic chk(input string what, input logic [14:0] e, input logic [14:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic drain(input string name);
		for (int w = 0; w < 300 && (exp_q.size() || wr_valid); w++) @(negedge sys_clk);
		chk("queue", 0, 15'(exp_q.size()));
		chk("busy", 0, bus_busy);
		chk("scl drive", 0, scl_out);
		// Freeze while idle; the next test proves no state was disturbed
		ce = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("frozen busy", 0, bus_busy);
		ce = 1'b1;
		$display("test %s done", name);
	endtask

	task automatic spi(input bit rd, input bit inc, input logic [5:0] a, input int nb,
			input int cut);
		logic [63:0] mo;
		logic [6:0]  ad;
		mo = {rd, inc, a, 56'h0};
		ad = {1'b0, a};
		for (int k = 0; k < nb; k++) begin
			mo[55-8*k -: 8] = rd ? 8'hff : 8'($urandom);
			if (!rd && (cut == 0 || k < nb - 1)) begin
				exp_q.push_back({ad, mo[55-8*k -: 8]});
				exp_mem[ad] = mo[55-8*k -: 8];
			end
			if (inc) ad++;
		end
		u_isrs_master_model.spi(8 + 8*nb - cut, mo, rd, miso);
		ad = {1'b0, a};
		for (int k = 0; k < nb && rd; k++) begin
			chk("spi read", {7'h0, exp_mem[ad]}, {7'h0, miso[55-8*k -: 8]});
			if (inc) ad++;
		end
		if (rd) chk("early drive", 0, u_isrs_master_model.early);
		drain("spi");
	endtask

	task automatic i2c_head(input logic [7:0] sub);
		u_isrs_master_model.i2c_start();
		u_isrs_master_model.i2c_byte({7'h1d, 1'b0, 1'b1}, rx);
		chk("addr ack", 0, rx[0]);
		u_isrs_master_model.i2c_byte({sub, 1'b1}, rx);
		chk("sub ack", 0, rx[0]);
	endtask

	task automatic i2c(input bit rd, input logic [7:0] sub, input int nb);
		logic [6:0] ad;
		logic [7:0] d;
		ad = sub[6:0];
		i2c_head(sub);
		if (rd) begin
			u_isrs_master_model.i2c_start();
			u_isrs_master_model.i2c_byte({7'h1d, 1'b1, 1'b1}, rx);
			chk("read ack", 0, rx[0]);
		end
		for (int k = 0; k < nb; k++) begin
			d = rd ? 8'hff : 8'($urandom);
			if (!rd) exp_q.push_back({ad, d});
			if (!rd) exp_mem[ad] = d;
			u_isrs_master_model.i2c_byte({d, rd && k == nb - 1}, rx);
			if (rd) chk("i2c read", {7'h0, exp_mem[ad]}, {7'h0, rx[8:1]});
			else chk("data ack", 0, rx[0]);
			if (sub[7]) ad++;
		end
		u_isrs_master_model.i2c_stop();
		drain("i2c");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#2000000;
		miscompares++;
		results();
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		three_wire_select = 1'b0;
		void'($urandom(32'h4a99df0a));
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'($urandom);
			exp_mem[i] = mem[i];
		end
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		repeat (6) @(negedge sys_clk);
		spi(0, 1, 6'h10, 3, 0);
		spi(0, 0, 6'h18, 2, 0);
		spi(0, 0, 6'h05, 2, 4);
		spi(1, 0, 6'h05, 1, 0);
		for (int m = 0; m < 2; m++) begin
			three_wire_select = 1'(m);
			spi(1, 1, 6'h10, 3, 0);
			spi(1, 0, 6'h18, 2, 0);
		end
		three_wire_select = 1'b0;
		i2c(0, 8'hb0, 3);
		i2c(0, 8'h2a, 1);
		i2c(1, 8'hb0, 3);
		i2c(1, 8'h2a, 1);
		u_isrs_master_model.i2c_start();
		u_isrs_master_model.i2c_byte({7'h1c, 1'b0, 1'b1}, rx);
		chk("foreign addr", 1, rx[0]);
		u_isrs_master_model.i2c_stop();
		drain("foreign address");
		results();
	end
endmodule // isrs_register_slave_tb_top
